/* hw/nbpc_pkg.sv */
// Constants, codes and carriers of the name-binding packet codec
package nbpc_pkg;
    // Datagram type and packet functions
    localparam logic [7:0] DDP_NBP = 8'h02;
    localparam logic [3:0] FN_BCAST = 4'h1;
    localparam logic [3:0] FN_LOOKUP = 4'h2;
    localparam logic [3:0] FN_REPLY = 4'h3;
    localparam logic [3:0] FN_FWD = 4'h4;
    localparam logic [3:0] ONE_TUPLE = 4'h1;
    localparam logic [3:0] MAX_TUPLES = 4'hF;
    // String limits and special characters
    localparam logic [7:0] MAX_STR = 8'h20;
    localparam logic [7:0] CH_EQ = 8'h3D;
    localparam logic [7:0] CH_APPROX = 8'hC5;
    localparam logic [7:0] CH_STAR = 8'h2A;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OWN = 8'h04;
    localparam logic [7:0] A_TXADDR = 8'h08;
    localparam logic [7:0] A_TXENUM = 8'h0C;
    localparam logic [7:0] A_TXBYTE = 8'h10;
    localparam logic [7:0] A_RXSTAT = 8'h14;
    localparam logic [7:0] A_RXADDR = 8'h18;
    localparam logic [7:0] A_CHECK = 8'h1C;
    localparam logic [7:0] A_LASTID = 8'h20;
    // Field positions
    localparam int B_START = 0;
    localparam int B_LAST = 8;
    localparam int B_NEW = 0;
    localparam int B_ERR = 1;
    localparam int B_HIT = 2;
    localparam int B_NODE = 3;
    // Reset values
    localparam logic [31:0] OWN_RST = 32'h0000_0000;
    localparam logic [7:0] ID_RST = 8'h00;
    // Call kinds and outcomes
    localparam logic [1:0] OP_REG = 2'h0;
    localparam logic [1:0] OP_REMOVE = 2'h1;
    localparam logic [1:0] OP_LOOKUP = 2'h2;
    localparam logic [1:0] OP_CONFIRM = 2'h3;
    localparam logic [2:0] RS_OK = 3'h0;
    localparam logic [2:0] RS_CONFLICT = 3'h1;
    localparam logic [2:0] RS_INVALID = 3'h2;
    localparam logic [2:0] RS_NOTFOUND = 3'h3;
    localparam logic [2:0] RS_WRONGSOCK = 3'h4;
    localparam logic [2:0] RS_FAIL = 3'h5;
    localparam logic [2:0] RS_DROP = 3'h6;
    typedef struct packed {
        logic [3:0] func;
        logic [3:0] count;
        logic [7:0] id;
        logic [7:0] enumer;
        logic zone_any;
        logic wild;
        logic id_match;
    } nbpc_rx_s;
endpackage : nbpc_pkg

/* hw/nbpc_codec.sv */
// Name-binding packet builder, parser and call checker with APB registers
`timescale 1ns/10ps
`default_nettype none
module nbpc_codec
    import nbpc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Received datagram bytes
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_LAST,
    input wire logic [7:0] RX_TYPE,
    // Transmitted datagram bytes
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    output logic [7:0] TX_TYPE,
    output logic [31:0] TX_DEST,
    input wire logic TX_READY
);
    typedef enum logic [2:0] {
        RX_HDR = 3'h0, RX_ID = 3'h1, RX_ADDR = 3'h3, RX_ENUM = 3'h2,
        RX_LEN = 3'h6, RX_STR = 3'h7, RX_DROP = 3'h5
    } nbpc_rx_e;
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0, TX_HDR = 3'h1, TX_ID = 3'h3, TX_ADDR = 3'h2,
        TX_ENUM = 3'h6, TX_BODY = 3'h7
    } nbpc_tx_e;

    ////////////////////////////////////////////////////////////////////
    nbpc_rx_e rx_state;
    nbpc_rx_s cur, info;
    logic [31:0] rx_addr;
    logic [5:0] rx_left;
    logic [1:0] rx_str, rx_bidx;
    logic [3:0] rx_tleft;
    logic rx_done, rx_bad, rx_new, rx_err, rx_fin, hdr_ok, wild_ch;
    nbpc_tx_e tx_state;
    logic [3:0] tx_func, tx_cnt;
    logic [7:0] tx_id, id_ctr, last_id, tx_enum;
    logic [31:0] own_addr, tx_addr, tx_shift;
    logic [1:0] tx_bidx;
    logic tx_req, tx_take, wr_en, rd_set, mapped, txb_sel, start;
    logic [1:0] chk_op;
    logic chk_hit, chk_node;
    logic [7:0] chk_limit;
    logic [2:0] chk_result;
    logic [3:0] next_cnt;

    ////////////////////////////////////////////////////////////////////
    // APB decode; only a byte push into a full output stalls
    assign txb_sel = PADDR == A_TXBYTE;
    assign PREADY = !(PSEL && PENABLE && PWRITE && txb_sel
                      && tx_state == TX_BODY && TX_VALID);
    assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
    assign rd_set = PSEL && !PENABLE && !PWRITE;
    assign mapped = PADDR[1:0] == 2'h0 && PADDR <= A_LASTID;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign start = wr_en && PADDR == A_CTRL && PWDATA[B_START]
                   && tx_state == TX_IDLE;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_set) begin
            case (PADDR)
                A_OWN: PRDATA <= own_addr;
                A_TXADDR: PRDATA <= tx_addr;
                A_TXENUM: PRDATA <= {24'h00_0000, tx_enum};
                A_RXSTAT: PRDATA <= {info.func, info.count, info.id,
                    info.enumer, 3'h0, info.id_match, info.wild,
                    info.zone_any, rx_err, rx_new};
                A_RXADDR: PRDATA <= rx_addr;
                A_CHECK: PRDATA <= {8'h00, chk_limit, 5'h00,
                    chk_result, 4'h0, chk_node, chk_hit, chk_op};
                A_LASTID: PRDATA <= {24'h00_0000, last_id};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            own_addr <= OWN_RST;
            tx_addr <= OWN_RST;
            tx_enum <= ID_RST;
            chk_op <= OP_REG;
            chk_hit <= 1'b0;
            chk_node <= 1'b0;
            chk_limit <= ID_RST;
        end else if (wr_en) begin
            case (PADDR)
                A_OWN: own_addr <= PWDATA;
                A_TXADDR: tx_addr <= PWDATA;
                // software keeps one enumerator per alias
                A_TXENUM: tx_enum <= PWDATA[7:0];
                A_CHECK: begin
                    chk_op <= PWDATA[1:0];
                    chk_hit <= PWDATA[B_HIT];
                    chk_node <= PWDATA[B_NODE];
                    chk_limit <= PWDATA[23:16];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Call outcome from the last parsed tuple and the table answer
    always_comb begin
        chk_result = RS_FAIL;
        case (chk_op)
            // register with special characters is invalid
            OP_REG: chk_result = (info.wild || !info.zone_any) ?
                RS_INVALID : (chk_hit ? RS_CONFLICT : RS_OK);
            OP_REMOVE: chk_result = (info.wild || !info.zone_any ||
                !chk_hit) ? RS_NOTFOUND : RS_OK;
            // no match, or a zero limit, means no reply
            OP_LOOKUP: chk_result = (chk_hit && chk_limit != 8'h00) ?
                RS_OK : RS_DROP;
            // same node but other socket is wrong socket
            OP_CONFIRM: begin
                if (info.wild || !info.zone_any)
                    chk_result = RS_FAIL;
                else if (chk_hit)
                    chk_result = RS_OK;
                else if (chk_node)
                    chk_result = RS_WRONGSOCK;
                else
                    chk_result = RS_FAIL;
            end
            default: chk_result = RS_FAIL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // function codes; requests hold one tuple
    assign hdr_ok = RX_TYPE == DDP_NBP && RX_DATA[3:0] != 4'h0
        && ((RX_DATA[7:4] == FN_REPLY) ||
            ((RX_DATA[7:4] == FN_BCAST || RX_DATA[7:4] == FN_LOOKUP ||
              RX_DATA[7:4] == FN_FWD) && RX_DATA[3:0] == ONE_TUPLE));
    assign wild_ch = RX_DATA == CH_EQ || RX_DATA == CH_APPROX;
    assign rx_fin = rx_str == 2'h2 && rx_tleft == ONE_TUPLE &&
        ((rx_state == RX_LEN && RX_DATA == 8'h00) ||
         (rx_state == RX_STR && rx_left == 6'h01));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_state <= RX_HDR;
            cur <= '0;
            rx_addr <= 32'h0000_0000;
            rx_left <= 6'h00;
            rx_str <= 2'h0;
            rx_bidx <= 2'h0;
            rx_tleft <= 4'h0;
            rx_done <= 1'b0;
            rx_bad <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_bad <= 1'b0;
            if (RX_VALID) begin
                case (rx_state)
                    RX_HDR: begin
                        cur.func <= RX_DATA[7:4];
                        cur.count <= RX_DATA[3:0];
                        cur.enumer <= 8'h00;
                        cur.wild <= 1'b0;
                        rx_tleft <= RX_DATA[3:0];
                        // other datagram types are not ours
                        if (!hdr_ok)
                            rx_state <= RX_LAST ? RX_HDR : RX_DROP;
                        else
                            rx_state <= RX_ID;
                    end
                    RX_ID: begin
                        cur.id <= RX_DATA;
                        // reply is matched to the last issued id
                        cur.id_match <= RX_DATA == last_id;
                        rx_bidx <= 2'h0;
                        rx_state <= RX_ADDR;
                    end
                    RX_ADDR: begin
                        if (cur.count == rx_tleft)
                            rx_addr <= {rx_addr[23:0], RX_DATA};
                        rx_bidx <= rx_bidx + 2'h1;
                        if (rx_bidx == 2'h3)
                            rx_state <= RX_ENUM;
                    end
                    RX_ENUM: begin
                        if (cur.func == FN_REPLY && cur.count == rx_tleft)
                            cur.enumer <= RX_DATA;
                        rx_str <= 2'h0;
                        rx_state <= RX_LEN;
                    end
                    RX_LEN: begin
                        rx_left <= RX_DATA[5:0];
                        if (rx_str == 2'h2)
                            cur.zone_any <= RX_DATA <= 8'h01;
                        if (RX_DATA > MAX_STR) begin
                            rx_bad <= 1'b1;
                            rx_state <= RX_LAST ? RX_HDR : RX_DROP;
                        end else if (RX_DATA != 8'h00)
                            rx_state <= RX_STR;
                        else if (rx_str != 2'h2)
                            rx_str <= rx_str + 2'h1;
                        else begin
                            rx_tleft <= rx_tleft - 4'h1;
                            rx_state <= RX_ADDR;
                        end
                    end
                    RX_STR: begin
                        // object, type, zone strings back to back
                        rx_left <= rx_left - 6'h01;
                        if (rx_str != 2'h2 && wild_ch)
                            cur.wild <= 1'b1;
                        // a lone asterisk zone means the zone asked
                        if (rx_str == 2'h2 && RX_DATA != CH_STAR)
                            cur.zone_any <= 1'b0;
                        if (rx_left == 6'h01) begin
                            rx_str <= rx_str + 2'h1;
                            rx_state <= RX_LEN;
                            if (rx_str == 2'h2) begin
                                rx_tleft <= rx_tleft - 4'h1;
                                rx_bidx <= 2'h0;
                                rx_state <= RX_ADDR;
                            end
                        end
                    end
                    default: ;
                endcase
                // end of datagram inside a tuple
                if (RX_LAST && !rx_fin) begin
                    rx_bad <= rx_state != RX_DROP &&
                        (rx_state != RX_HDR || hdr_ok);
                    rx_state <= RX_HDR;
                end else if (rx_fin) begin
                    rx_done <= 1'b1;
                    rx_state <= RX_LAST ? RX_HDR : RX_DROP;
                end
            end
        end
    end

    // Sticky receive flags; an event in the clearing cycle wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_new <= 1'b0;
            rx_err <= 1'b0;
            info <= '0;
        end else begin
            // Zone flag is final in cur; the bus may carry a new frame now
            if (rx_done)
                info <= cur;
            rx_new <= rx_done || (rx_new && !(wr_en &&
                PADDR == A_RXSTAT && PWDATA[B_NEW]));
            rx_err <= rx_bad || (rx_err && !(wr_en &&
                PADDR == A_RXSTAT && PWDATA[B_ERR]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign tx_req = tx_func != FN_REPLY;
    assign tx_take = TX_VALID && TX_READY;
    // reply count capped by nibble and match limit
    always_comb begin
        next_cnt = PWDATA[11:8];
        if (chk_limit != 8'h00 && chk_limit < {4'h0, next_cnt})
            next_cnt = chk_limit[3:0];
        if (PWDATA[7:4] != FN_REPLY)
            next_cnt = ONE_TUPLE;
    end
    // everything sent is of the name-binding type
    assign TX_TYPE = DDP_NBP;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_state <= TX_IDLE;
            tx_func <= 4'h0;
            tx_cnt <= 4'h0;
            tx_id <= ID_RST;
            id_ctr <= ID_RST;
            last_id <= ID_RST;
            tx_shift <= 32'h0000_0000;
            tx_bidx <= 2'h0;
            TX_VALID <= 1'b0;
            TX_DATA <= 8'h00;
            TX_LAST <= 1'b0;
            TX_DEST <= 32'h0000_0000;
        end else begin
            case (tx_state)
                TX_IDLE: if (start) begin
                    tx_func <= PWDATA[7:4];
                    tx_cnt <= next_cnt;
                    // reply takes the id software copied in
                    tx_id <= PWDATA[7:4] == FN_REPLY ?
                        PWDATA[23:16] : id_ctr;
                    // reply goes to the requester's address
                    TX_DEST <= PWDATA[7:4] == FN_REPLY ? rx_addr : tx_addr;
                    TX_DATA <= {PWDATA[7:4], next_cnt};
                    TX_VALID <= 1'b1;
                    TX_LAST <= 1'b0;
                    tx_state <= TX_HDR;
                end
                TX_HDR: if (tx_take) begin
                    TX_DATA <= tx_id;
                    tx_state <= TX_ID;
                end
                TX_ID: if (tx_take) begin
                    if (tx_req) begin
                        id_ctr <= id_ctr + 8'h01;
                        last_id <= tx_id;
                    end
                    // request tuple carries our own address
                    tx_shift <= tx_req ? own_addr : tx_addr;
                    TX_DATA <= tx_req ? own_addr[31:24] : tx_addr[31:24];
                    tx_bidx <= 2'h0;
                    tx_state <= TX_ADDR;
                end
                TX_ADDR: if (tx_take) begin
                    tx_bidx <= tx_bidx + 2'h1;
                    tx_shift <= {tx_shift[23:0], 8'h00};
                    TX_DATA <= tx_shift[23:16];
                    if (tx_bidx == 2'h3) begin
                        TX_DATA <= tx_req ? 8'h00 : tx_enum;
                        tx_state <= TX_ENUM;
                    end
                end
                TX_ENUM: if (tx_take) begin
                    TX_VALID <= 1'b0;
                    tx_state <= TX_BODY;
                end
                TX_BODY: begin
                    if (tx_take) begin
                        TX_VALID <= 1'b0;
                        if (TX_LAST)
                            tx_state <= TX_IDLE;
                    end
                    if (wr_en && txb_sel && !TX_VALID) begin
                        TX_DATA <= PWDATA[7:0];
                        TX_LAST <= PWDATA[B_LAST];
                        TX_VALID <= 1'b1;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_tx_type;
        TX_VALID |-> TX_TYPE == DDP_NBP;
    endproperty
    a_tx_type: assert property (p_tx_type)
        else $error("sent datagram type is not 2");
    property p_req_one;
        tx_state == TX_HDR && tx_req |-> TX_DATA[3:0] == ONE_TUPLE;
    endproperty
    a_req_one: assert property (p_req_one)
        else $error("request header count is not one");
    property p_id_step;
        tx_state == TX_ID && tx_take && tx_req |=>
            id_ctr == $past(id_ctr) + 8'h01 && last_id == $past(tx_id);
    endproperty
    a_id_step: assert property (p_id_step)
        else $error("request id did not advance");
    property p_reply_id;
        tx_state == TX_ID && !tx_req |-> TX_DATA == tx_id;
    endproperty
    a_reply_id: assert property (p_reply_id)
        else $error("reply id not echoed");
    property p_own_addr;
        tx_state == TX_ID && tx_take && tx_req |=>
            TX_DATA == $past(own_addr[31:24]);
    endproperty
    a_own_addr: assert property (p_own_addr)
        else $error("request tuple lacks own address");
    property p_len_drop;
        RX_VALID && !RX_LAST && rx_state == RX_LEN && RX_DATA > MAX_STR
            |=> rx_state == RX_DROP ##1 rx_err;
    endproperty
    a_len_drop: assert property (p_len_drop)
        else $error("oversized string not discarded");
    property p_remove_wild;
        chk_op == OP_REMOVE && info.wild |-> chk_result == RS_NOTFOUND;
    endproperty
    a_remove_wild: assert property (p_remove_wild)
        else $error("wildcard removal not refused");
    property p_reply_cap;
        tx_state == TX_HDR && !tx_req && chk_limit != 8'h00 |->
            {4'h0, TX_DATA[3:0]} <= chk_limit;
    endproperty
    a_reply_cap: assert property (p_reply_cap)
        else $error("reply exceeds match limit");
    property p_done_flag;
        rx_done |=> rx_new && info.func == $past(cur.func);
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("parsed packet not posted");

    c_tx_done: cover property (tx_state == TX_BODY && tx_take && TX_LAST);
    c_rx_done: cover property (rx_done);
    c_rx_bad: cover property (rx_bad);
    c_wrongsock: cover property (chk_result == RS_WRONGSOCK);
endmodule : nbpc_codec
`default_nettype wire

/* sim/nbpc_peer.sv */
// Far-side peer: feeds received datagrams and sinks sent bytes
`timescale 1ns/10ps
`default_nettype none
module nbpc_peer
    import nbpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Datagram into the codec
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic [7:0] rx_type,
    // Datagram out of the codec
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic [8:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_type = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // byte stream, one per cycle; idle data inverted, not held
    task automatic send(input logic [7:0] t, input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= b[i];
            rx_last <= (i == b.size() - 1);
            rx_type <= t;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask : send
    ////////////////////////////////////////////////////////////////////////
    // Sink; slow mode stalls every other cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready)
                got.push_back({tx_last, tx_data});
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end
endmodule : nbpc_peer
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench of the name-binding packet codec
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import nbpc_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic e, pready, pslverr, rx_valid, rx_last, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_data, rx_type, tx_data, tx_type, id1;
    logic [31:0] prdata, q, tx_dest;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] cw[10] = '{32'h0, 32'h4, 32'h1, 32'h5, 32'h10002, 32'h6,
        32'h10006, 32'hF, 32'hB, 32'h3};
    logic [2:0] cr[10] = '{RS_OK, RS_CONFLICT, RS_NOTFOUND, RS_OK, RS_DROP,
        RS_DROP, RS_OK, RS_OK, RS_WRONGSOCK, RS_FAIL};
    always #25 CLK = ~CLK;
    nbpc_codec dut_u (.CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_TYPE(rx_type),
        .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
        .TX_TYPE(tx_type), .TX_DEST(tx_dest), .TX_READY(tx_ready));
    nbpc_peer peer_u (.clk(CLK), .rst(RST), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_type(rx_type),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, s, x);
        end
    endtask : chk
    // Held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        @(posedge CLK);
        while (pready !== 1'b1 && n < 200) begin
            @(posedge CLK);
            n++;
        end
        if (pready !== 1'b1)
            failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wt(input int k);
        int n;
        n = 0;
        while (peer_u.got.size() < k && n < 500) begin
            @(posedge CLK);
            n++;
        end
    endtask : wt
    task automatic txchk(input logic [8:0] x[$]);
        wt(x.size());
        chk(peer_u.got.size(), x.size());
        foreach (x[i]) chk(peer_u.got[i], x[i]);
        peer_u.got.delete();
    endtask : txchk
    // Clears status, sends one single-tuple datagram, reads status
    task automatic rx(input logic [7:0] t, h, i, n, l, o);
        apb(1'b1, A_RXSTAT, 32'h3);
        peer_u.send(t, '{h, i, 8'h12, 8'h34, 8'h56, 8'h78, n, l, o, 8'h01,
            8'h62, 8'h00});
        repeat (2) @(posedge CLK);
        apb(1'b0, A_RXSTAT, 32'h0);
    endtask : rx
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        apb(1'b0, A_LASTID, 32'h0);
        chk(q, {24'h0, ID_RST});
        apb(1'b0, 8'h24, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
        rx(DDP_NBP, 8'h21, 8'h5A, 8'h77, 8'h01, 8'h61);
        chk(q, 32'h215A0005);
        apb(1'b0, A_RXADDR, 32'h0);
        chk(q, 32'h12345678);
        rx(8'h03, 8'h21, 8'h5A, 8'h77, 8'h01, 8'h61);
        chk(q[1:0], 2'b00);
        rx(DDP_NBP, 8'h22, 8'h5A, 8'h77, 8'h01, 8'h61);
        chk(q[1:0], 2'b00);
        rx(DDP_NBP, 8'h21, 8'h5A, 8'h77, 8'h21, 8'h61);
        chk(q[1:0], 2'b10);
        // outcome table on a plain name
        rx(DDP_NBP, 8'h21, 8'h5A, 8'h77, 8'h01, 8'h61);
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, A_CHECK, cw[i]);
            apb(1'b0, A_CHECK, 32'h0);
            chk(q[10:8], cr[i]);
        end
        // a named zone is refused for register
        peer_u.send(DDP_NBP, '{8'h21, 8'h5A, 8'h12, 8'h34, 8'h56, 8'h78,
            8'h00, 8'h01, 8'h61, 8'h01, 8'h62, 8'h01, 8'h78});
        repeat (2) @(posedge CLK);
        apb(1'b1, A_CHECK, 32'h0);
        apb(1'b0, A_CHECK, 32'h0);
        chk(q[10:8], RS_INVALID);
        foreach (cr[i]) if (i < 2) begin
            rx(DDP_NBP, 8'h21, 8'h5A, 8'h77, 8'h01, i ? CH_APPROX : CH_EQ);
            chk(q[3], 1'b1);
            apb(1'b1, A_CHECK, 32'h5);
            apb(1'b0, A_CHECK, 32'h0);
            chk(q[10:8], RS_NOTFOUND);
        end
        apb(1'b1, A_OWN, 32'h0A0B0C0D);
        apb(1'b1, A_TXADDR, 32'hA1B2C3D4);
        peer_u.slow <= 1'b1;
        apb(1'b1, A_CTRL, 32'h00000521);
        wt(7);
        apb(1'b1, A_TXBYTE, 32'h61);
        apb(1'b1, A_TXBYTE, 32'h100);
        apb(1'b0, A_LASTID, 32'h0);
        id1 = q[7:0];
        txchk('{9'h21, {1'b0, id1}, 9'h0A, 9'h0B, 9'h0C, 9'h0D, 9'h0, 9'h61,
            9'h100});
        chk(tx_type, DDP_NBP);
        chk(tx_dest, 32'hA1B2C3D4);
        apb(1'b1, A_CTRL, 32'h00000011);
        wt(7);
        apb(1'b1, A_TXBYTE, 32'h100);
        apb(1'b0, A_LASTID, 32'h0);
        chk(q[7:0] == id1, 1'b0);
        id1 = q[7:0];
        txchk('{9'h11, {1'b0, id1}, 9'h0A, 9'h0B, 9'h0C, 9'h0D, 9'h0,
            9'h100});
        rx(DDP_NBP, 8'h31, id1, 8'h44, 8'h01, 8'h61);
        chk(q[31:4], {4'h3, 4'h1, id1, 8'h44, 4'h1});
        // reply echoes id and carries enumerator
        peer_u.slow <= 1'b0;
        apb(1'b1, A_CHECK, 32'h0);
        apb(1'b1, A_TXENUM, 32'h55);
        apb(1'b1, A_CTRL, 32'h00C30231);
        wt(7);
        apb(1'b1, A_TXBYTE, 32'h100);
        txchk('{9'h32, 9'hC3, 9'hA1, 9'hB2, 9'hC3, 9'hD4, 9'h55,
            9'h100});
        chk(tx_dest, 32'h12345678);
        // match limit of one caps the reply count
        apb(1'b1, A_CHECK, 32'h0001_0000);
        apb(1'b1, A_CTRL, 32'h00C30231);
        wt(7);
        apb(1'b1, A_TXBYTE, 32'h100);
        txchk('{9'h31, 9'hC3, 9'hA1, 9'hB2, 9'hC3, 9'hD4, 9'h55,
            9'h100});
        test_done();
    end
endmodule : tb_top
`default_nettype wire
